// ---- io_diag_pkg.sv ----
`default_nettype none

package io_diag_pkg;

	// Register byte offsets on the APB.
	localparam logic [7:0] OFF_DATA = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_SKIP = 8'h08;
	localparam logic [7:0] OFF_GLOBAL = 8'h0C;
	localparam logic [7:0] OFF_GSEL = 8'h10;
	localparam logic [7:0] OFF_IDREAD = 8'h14;
	localparam logic [7:0] OFF_DMA_ADDR = 8'h18;
	localparam logic [7:0] OFF_DMA_CNT = 8'h1C;
	localparam logic [7:0] OFF_CFG_ADDR = 8'h20;

	// Bit positions in the control register.
	localparam int CTRL_SET_BIT = 0;
	localparam int CTRL_CLF_BIT = 1;
	localparam int CTRL_CLR_BIT = 2;
	localparam int CTRL_BRK_BIT = 3;
	localparam int CTRL_RD_CONTROL = 0;
	localparam int CTRL_RD_FLAG = 1;
	localparam int CTRL_RD_BRK = 3;
	localparam int CTRL_RD_MODE7 = 4;
	localparam int CTRL_RD_MODE_LSB = 8;

	// Bit positions of the select latch and of answer words.
	localparam int GSEL_EN_BIT = 6;
	localparam int RESP_VALID_BIT = 16;

	// Diagnose mode numbers written to the global location.
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_ENUM = 3'h1;
	localparam logic [2:0] MODE_STATUS = 3'h2;
	localparam logic [2:0] MODE_LOOP = 3'h3;
	localparam logic [2:0] MODE_NOSRQ = 3'h7;

	// Loopback engine states.
	typedef enum logic [1:0] {
		DMA_IDLE = 2'b00,
		DMA_RUN = 2'b01
	} dma_state_e;

	// Values after reset, and the loopback count step.
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [5:0] RST_GSEL = 6'h00;
	localparam logic [2:0] RST_MODE = 3'h0;
	localparam logic [15:0] CNT_STEP = 16'h0001;

endpackage : io_diag_pkg

`default_nettype wire

// ---- resp_word.sv ----
`timescale 1ns/1ns
`default_nettype none

// Forms the identity word or the status word that a diagnose read returns.
module resp_word
	import io_diag_pkg::*;
(
	// Selection.
	input wire logic want_status,
	// Identity fields.
	input wire logic [1:0] smart,
	input wire logic [4:0] card_type,
	input wire logic [2:0] card_rev,
	input wire logic [5:0] sel_code,
	// Status fields.
	input wire logic brk_en,
	input wire logic pri_rx,
	input wire logic control,
	input wire logic flag,
	input wire logic gr_en,
	input wire logic [5:0] gr_val,
	// Result.
	output logic [15:0] word
);

	logic gr_match;

	// Identity is laid out in four fields; status keeps the top two bits at zero.
	always_comb begin
		gr_match = (gr_val == sel_code);
		if (want_status) begin
			word = {2'b00, brk_en, pri_rx, 2'b11, control, flag, gr_match, gr_en, gr_val};
		end else begin
			word = {smart, card_type, card_rev, sel_code};
		end
	end

endmodule : resp_word

`default_nettype wire

// ---- io_diag_if.sv ----
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// One I/O interface card: flag and control handshake plus diagnose modes.
module io_diag_if
	import io_diag_pkg::*;
#(
	parameter logic [1:0] ID_SMART = 2'h1, // Arbitrary identity value.
	parameter logic [4:0] ID_TYPE = 5'h05, // Arbitrary identity value.
	parameter logic [2:0] ID_REV = 3'h1, // Arbitrary identity value.
	parameter logic [5:0] SEL_CODE = 6'h10
) (
	// Clock, reset and enable.
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Backplane priority chain and system reset.
	input wire logic pri_in,
	output logic pri_out,
	input wire logic control_reset_signal,
	// Service request toward the DMA logic.
	input wire logic dma_service_request,
	output logic srq_gated,
	// Attached device.
	output logic dev_start,
	output logic [15:0] dev_out_data,
	input wire logic dev_done,
	input wire logic [15:0] dev_in_data,
	// Memory write port used by the loopback test.
	output logic mem_wr,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_data
);

	typedef struct packed {
		logic control;
		logic flag;
		logic brk_en;
		logic [15:0] out_buf;
		logic [15:0] in_buf;
		logic [2:0] mode;
		logic mode7;
		logic [5:0] gr_val;
		logic gr_en;
		logic pass_en;
		dma_state_e dma;
		logic [15:0] dma_addr;
		logic [15:0] dma_cnt;
		logic [15:0] cfg_addr;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic pri_out;
		logic srq_out;
		logic dev_start;
		logic mem_wr;
		logic [15:0] mem_addr;
		logic [15:0] mem_data;
	} state_s;

	localparam state_s RST_STATE = '{
		control: 1'b0, flag: 1'b0, brk_en: 1'b0,
		out_buf: RST_WORD, in_buf: RST_WORD,
		mode: RST_MODE, mode7: 1'b0,
		gr_val: RST_GSEL, gr_en: 1'b0, pass_en: 1'b1,
		dma: DMA_IDLE, dma_addr: RST_WORD, dma_cnt: RST_WORD, cfg_addr: RST_WORD,
		rdata: 32'h00000000, ready: 1'b0, slverr: 1'b0,
		pri_out: 1'b0, srq_out: 1'b0, dev_start: 1'b0,
		mem_wr: 1'b0, mem_addr: RST_WORD, mem_data: RST_WORD
	};

	state_s s;
	state_s next_s;
	logic [15:0] id_word;
	logic [15:0] stat_word;

	// True for every offset that holds a register.
	function automatic logic mapped(input logic [7:0] a);
		case (a)
			OFF_DATA, OFF_CTRL, OFF_SKIP, OFF_GLOBAL, OFF_GSEL,
			OFF_IDREAD, OFF_DMA_ADDR, OFF_DMA_CNT, OFF_CFG_ADDR: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction : mapped

	// True for the modes that walk the priority chain.
	function automatic logic chain_mode(input logic [2:0] m);
		chain_mode = (m == MODE_ENUM) || (m == MODE_STATUS);
	endfunction : chain_mode

	// Identity word for mode 1 answers.
	resp_word u_id (
		.want_status(1'b0),
		.smart(ID_SMART),
		.card_type(ID_TYPE),
		.card_rev(ID_REV),
		.sel_code(SEL_CODE),
		.brk_en(s.brk_en),
		.pri_rx(pri_in),
		.control(s.control),
		.flag(s.flag),
		.gr_en(s.gr_en),
		.gr_val(s.gr_val),
		.word(id_word)
	);

	// Status word for mode 2 answers.
	resp_word u_stat (
		.want_status(1'b1),
		.smart(ID_SMART),
		.card_type(ID_TYPE),
		.card_rev(ID_REV),
		.sel_code(SEL_CODE),
		.brk_en(s.brk_en),
		.pri_rx(pri_in),
		.control(s.control),
		.flag(s.flag),
		.gr_en(s.gr_en),
		.gr_val(s.gr_val),
		.word(stat_word)
	);

	// Next-state logic for the whole card.
	always_comb begin
		logic first;
		logic done;
		logic accepts;
		logic chain_hit;
		logic [2:0] mval;
		logic [15:0] answer;
		first = 1'b0;
		done = 1'b0;
		accepts = 1'b0;
		chain_hit = 1'b0;
		mval = MODE_OFF;
		answer = RST_WORD;
		next_s = s;
		next_s.dev_start = 1'b0;
		next_s.mem_wr = 1'b0;

		// The access phase takes one wait state so that read data leaves a flop.
		first = psel && penable && !s.ready;
		done = psel && penable && s.ready;
		next_s.ready = first;
		next_s.slverr = first && !mapped(paddr);

		// Only this card, or every card when the latch is off, takes a mode.
		accepts = !s.gr_en || (s.gr_val == SEL_CODE);
		chain_hit = chain_mode(s.mode) && pri_in && !s.pass_en;
		answer = (s.mode == MODE_STATUS) ? stat_word : id_word;

		// Mode 7 cuts the incoming service request.
		next_s.srq_out = dma_service_request && !s.mode7;

		// In a chain mode, priority goes on only after this card has answered.
		next_s.pri_out = pri_in && (s.pass_en || !chain_mode(s.mode));

		// Read data is captured on the first access cycle; a write answers with zero.
		if (first) begin
			next_s.rdata = 32'h00000000;
		end
		if (first && !pwrite) begin
			case (paddr)
				OFF_DATA: next_s.rdata[15:0] = s.in_buf;
				OFF_CTRL: begin
					next_s.rdata[CTRL_RD_CONTROL] = s.control;
					next_s.rdata[CTRL_RD_FLAG] = s.flag;
					next_s.rdata[CTRL_RD_BRK] = s.brk_en;
					next_s.rdata[CTRL_RD_MODE7] = s.mode7;
					next_s.rdata[CTRL_RD_MODE_LSB +: 3] = s.mode;
				end
				OFF_SKIP: next_s.rdata[0] = s.flag;
				OFF_GLOBAL: begin
					if (chain_hit) begin
						next_s.rdata[15:0] = answer;
						next_s.rdata[RESP_VALID_BIT] = 1'b1;
						next_s.pass_en = 1'b1;
					end
					// Without priority the valid bit stays low: no response.
				end
				OFF_IDREAD: begin
					if (chain_mode(s.mode)) begin
						next_s.rdata[15:0] = answer;
						next_s.rdata[RESP_VALID_BIT] = 1'b1;
					end
				end
				OFF_GSEL: begin
					next_s.rdata[5:0] = s.gr_val;
					next_s.rdata[GSEL_EN_BIT] = s.gr_en;
				end
				OFF_DMA_ADDR: next_s.rdata[15:0] = s.dma_addr;
				OFF_DMA_CNT: next_s.rdata[15:0] = s.dma_cnt;
				OFF_CFG_ADDR: next_s.rdata[15:0] = s.cfg_addr;
				default: next_s.rdata = 32'h00000000;
			endcase
		end

		// Writes take effect at the completing edge.
		if (done && pwrite) begin
			case (paddr)
				OFF_DATA: next_s.out_buf = pwdata[15:0];
				OFF_CTRL: begin
					next_s.brk_en = pwdata[CTRL_BRK_BIT];
					if (pwdata[CTRL_CLR_BIT]) begin
						next_s.control = 1'b0;
						if (pwdata[CTRL_CLF_BIT]) begin
							next_s.flag = 1'b0;
						end
					end else if (pwdata[CTRL_SET_BIT]) begin
						next_s.control = 1'b1;
						if (pwdata[CTRL_CLF_BIT]) begin
							next_s.flag = 1'b0;
						end
						// Loopback keeps the device quiet.
						next_s.dev_start = (s.mode != MODE_LOOP);
					end
				end
				OFF_GLOBAL: begin
					mval = pwdata[2:0];
					if (accepts) begin
						// The select latch itself is left as it is.
						next_s.mode = mval;
						if (mval == MODE_NOSRQ) begin
							next_s.mode7 = 1'b1;
						end
						if (chain_mode(mval)) begin
							next_s.pass_en = 1'b0;
						end
						if (mval == MODE_LOOP && s.dma_cnt != RST_WORD) begin
							next_s.dma = DMA_RUN;
						end
						// Values 4 to 6 are stored but steer nothing.
					end
				end
				OFF_GSEL: begin
					next_s.gr_val = pwdata[5:0];
					next_s.gr_en = pwdata[GSEL_EN_BIT];
				end
				OFF_DMA_ADDR: next_s.dma_addr = pwdata[15:0];
				OFF_DMA_CNT: next_s.dma_cnt = pwdata[15:0];
				OFF_CFG_ADDR: next_s.cfg_addr = pwdata[15:0];
				default: next_s.mode = next_s.mode;
			endcase
		end

		// Loopback engine writes one word per cycle until the count wraps to zero.
		case (s.dma)
			DMA_IDLE: next_s.dma = next_s.dma;
			DMA_RUN: begin
				if (s.mode != MODE_LOOP) begin
					next_s.dma = DMA_IDLE;
				end else begin
					next_s.mem_wr = 1'b1;
					next_s.mem_addr = s.dma_addr;
					next_s.mem_data = s.cfg_addr;
					next_s.cfg_addr = 16'(s.cfg_addr + CNT_STEP);
					next_s.dma_addr = 16'(s.dma_addr + CNT_STEP);
					next_s.dma_cnt = 16'(s.dma_cnt + CNT_STEP);
					if (16'(s.dma_cnt + CNT_STEP) == RST_WORD) begin
						next_s.dma = DMA_IDLE;
					end
				end
			end
			default: next_s.dma = DMA_IDLE;
		endcase

		// System reset returns the card to control clear, flag clear, mode 7 off.
		if (control_reset_signal) begin
			next_s.control = 1'b0;
			next_s.flag = 1'b0;
			next_s.mode7 = 1'b0;
			if (s.mode == MODE_NOSRQ) begin
				next_s.mode = MODE_OFF;
			end
		end

		// Completion sets the flag after any clear, so the set is never lost.
		if (dev_done) begin
			next_s.flag = 1'b1;
			next_s.in_buf = dev_in_data;
		end
	end

	// All state is held here and frozen while the enable is low.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s <= RST_STATE;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// Outputs come straight from the state flops.
	assign prdata = s.rdata;
	assign pready = s.ready;
	assign pslverr = s.slverr;
	assign pri_out = s.pri_out;
	assign srq_gated = s.srq_out;
	assign dev_start = s.dev_start;
	assign dev_out_data = s.out_buf;
	assign mem_wr = s.mem_wr;
	assign mem_addr = s.mem_addr;
	assign mem_data = s.mem_data;

endmodule : io_diag_if

`default_nettype wire

// ---- io_diag_chk_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none

// Watches bus timing, device starts, loopback words and gated requests.
module io_diag_chk
	import io_diag_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_n,
	// Bus.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Chain, requests and device.
	input wire logic pri_in,
	input wire logic pri_out,
	input wire logic dma_service_request,
	input wire logic srq_gated,
	input wire logic dev_start,
	input wire logic mem_wr,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_data
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// An access phase that is answered on its second cycle.
	sequence s_access;
		psel && penable && !pready ##1 pready;
	endsequence

	// Two loopback words on consecutive cycles.
	sequence s_two_words;
		mem_wr ##1 mem_wr;
	endsequence

	// Bus answer timing and refusal.
	a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("late ready");
	a_ready_pulse: assert property (s_access |=> !pready) else $error("ready too long");
	a_idle_ready: assert property (!psel |=> !pready) else $error("ready without request");
	a_err_data: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error reply");
	// Device start only after a control write, and only one cycle long.
	a_start_cause: assert property (dev_start |-> $past(psel && penable && pready && pwrite
		&& paddr == OFF_CTRL)) else $error("start without write");
	a_start_once: assert property (dev_start |=> !dev_start) else $error("start too long");
	// Loopback words step address and data by one.
	a_loop_step: assert property (s_two_words |-> mem_addr == $past(mem_addr) + 16'h1
		&& mem_data == $past(mem_data) + 16'h1) else $error("loop step wrong");
	// Requests and priority are only passed on when present.
	a_srq_cause: assert property (srq_gated |-> $past(dma_service_request)) else $error("stray srq");
	a_pri_gate: assert property (!pri_in |=> !pri_out) else $error("stray priority");
endmodule : io_diag_chk

bind io_diag_if io_diag_chk u_chk (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.pri_in(pri_in),
	.pri_out(pri_out),
	.dma_service_request(dma_service_request),
	.srq_gated(srq_gated),
	.dev_start(dev_start),
	.mem_wr(mem_wr),
	.mem_addr(mem_addr),
	.mem_data(mem_data)
);

`default_nettype wire

// ---- dev_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// Attached device: answers a start after a set delay with the inverted output word.
module dev_model (
	// Clock and control.
	input wire logic sys_clk,
	input wire logic [3:0] dly,
	// Device lines.
	input wire logic dev_start,
	input wire logic [15:0] dev_out_data,
	output logic dev_done,
	output logic [15:0] dev_in_data
);
	int n = 0;

	initial dev_done = 1'h0;
	initial dev_in_data = 16'h0F0F;

	// Data wanders outside the completion cycle so stale data never matches.
	always @(posedge sys_clk) begin
		dev_done <= 1'h0;
		dev_in_data <= ~dev_in_data;
		if (dev_start) begin
			n <= dly;
		end else if (n != 0) begin
			n <= n - 1;
		end
		if (n == 1 && !dev_start) begin
			dev_done <= 1'h1;
			dev_in_data <= ~dev_out_data;
		end
	end
endmodule : dev_model

`default_nettype wire

// ---- io_interface_diagnose_modes_test.sv ----
`timescale 1ns/1ns
`default_nettype none

// Drives one card over the bus and judges what it answers.
module io_interface_diagnose_modes_test
	import io_diag_pkg::*;
;
	localparam logic [31:0] ID_RESP = {15'h0, 1'h1, 2'h1, 5'h05, 3'h1, 6'h10};
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	logic ce = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic pri_in = 1'h0;
	logic control_reset_signal = 1'h0;
	logic dma_service_request = 1'h0;
	logic [3:0] dly = 4'h1;
	logic [31:0] prdata, rd;
	logic pready, pslverr, pri_out, srq_gated, dev_start, dev_done, mem_wr, err;
	logic [15:0] dev_out_data, dev_in_data, mem_addr, mem_data, last_addr, last_data;
	int n_mismatch = 0;
	int checked = 0;
	int n_mem = 0;
	int n_start = 0;

	always #10 sys_clk = ~sys_clk;

	io_diag_if DUT (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ce(ce),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.pri_in(pri_in),
		.pri_out(pri_out),
		.control_reset_signal(control_reset_signal),
		.dma_service_request(dma_service_request),
		.srq_gated(srq_gated),
		.dev_start(dev_start),
		.dev_out_data(dev_out_data),
		.dev_done(dev_done),
		.dev_in_data(dev_in_data),
		.mem_wr(mem_wr),
		.mem_addr(mem_addr),
		.mem_data(mem_data)
	);
	dev_model far_dev (
		.sys_clk(sys_clk),
		.dly(dly),
		.dev_start(dev_start),
		.dev_out_data(dev_out_data),
		.dev_done(dev_done),
		.dev_in_data(dev_in_data)
	);

	// Counts loopback words and device starts.
	always @(posedge sys_clk) begin
		if (mem_wr) begin
			n_mem++;
			last_addr = mem_addr;
			last_data = mem_data;
		end
		if (dev_start) n_start++;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	// One bus transfer: setup, then access until ready.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		// Wait for the answer; only the watchdog ends a hung wait.
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(rd, e);
	endtask : rdchk

	// Polled transfers with a slow and then a prompt device.
	task automatic t_xfer;
		int k;
		for (logic [15:0] w = 16'h1234; w < 16'h1236; w++) begin
			dly <= w[0] ? 4'h1 : 4'h8;
			wr(OFF_DATA, {16'h0, w});
			wr(OFF_CTRL, 32'h3);
			chk({16'h0, dev_out_data}, {16'h0, w});
			if (!w[0]) rdchk(OFF_CTRL, 32'h1);
			if (!w[0]) rdchk(OFF_SKIP, 32'h0);
			k = 0;
			do apb(1'h0, OFF_SKIP, 32'h0); while (rd[0] !== 1'h1 && ++k < 20);
			chk(rd, 32'h1);
			rdchk(OFF_DATA, {16'h0, ~w});
		end
		wr(OFF_CTRL, 32'h6);
		chk(n_start, 2);
		$display("t_xfer done");
	endtask : t_xfer

	// Mode acceptance through the select latch, and mode numbers 0 to 6.
	task automatic t_modes;
		wr(OFF_GSEL, 32'h51);
		wr(OFF_GLOBAL, 32'h1);
		rdchk(OFF_CTRL, 32'h0);
		wr(OFF_GSEL, 32'h50);
		for (int m = 1; m < 7; m++) begin
			wr(OFF_GLOBAL, 32'(m));
			rdchk(OFF_CTRL, 32'(m) << 8);
		end
		rdchk(OFF_GSEL, 32'h50);
		wr(OFF_GLOBAL, 32'h0);
		rdchk(OFF_CTRL, 32'h0);
		$display("t_modes done");
	endtask : t_modes

	// Chain enumeration, directed identity read and status word.
	task automatic t_enum;
		wr(OFF_GSEL, 32'h0);
		pri_in <= 1'h1;
		wr(OFF_GLOBAL, 32'h1);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, pri_out}, 32'h0);
		rdchk(OFF_IDREAD, ID_RESP);
		rdchk(OFF_GLOBAL, ID_RESP);
		@(posedge sys_clk);
		chk({31'h0, pri_out}, 32'h1);
		rdchk(OFF_GLOBAL, 32'h0);
		wr(OFF_GLOBAL, 32'h2);
		rdchk(OFF_GLOBAL, 32'h11C00);
		wr(OFF_GLOBAL, 32'h0);
		$display("t_enum done");
	endtask : t_enum

	// Loopback of three words; a start command meanwhile reaches no device.
	task automatic t_loop;
		int starts;
		wr(OFF_DMA_ADDR, 32'h100);
		wr(OFF_CFG_ADDR, 32'h40);
		wr(OFF_DMA_CNT, 32'hFFFD);
		starts = n_start;
		wr(OFF_GLOBAL, 32'h3);
		repeat (8) @(posedge sys_clk);
		wr(OFF_CTRL, 32'h1);
		repeat (2) @(posedge sys_clk);
		chk(n_mem, 3);
		chk(n_start - starts, 0);
		chk({16'h0, last_addr}, 32'h102);
		chk({16'h0, last_data}, 32'h42);
		rdchk(OFF_DMA_CNT, 32'h0);
		rdchk(OFF_CFG_ADDR, 32'h43);
		wr(OFF_GLOBAL, 32'h0);
		wr(OFF_CTRL, 32'h6);
		$display("t_loop done");
	endtask : t_loop

	// Service request blocking, removal by system reset, and an unmapped read.
	task automatic t_srq;
		dma_service_request <= 1'h1;
		repeat (2) @(posedge sys_clk);
		chk({31'h0, srq_gated}, 32'h1);
		wr(OFF_GLOBAL, 32'h7);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, srq_gated}, 32'h0);
		wr(OFF_GLOBAL, 32'h0);
		rdchk(OFF_CTRL, 32'h10);
		control_reset_signal <= 1'h1;
		@(posedge sys_clk);
		control_reset_signal <= 1'h0;
		repeat (2) @(posedge sys_clk);
		chk({31'h0, srq_gated}, 32'h1);
		apb(1'h0, 8'hFC, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		// A low enable freezes the card: a new request is not passed on until it rises.
		dma_service_request <= 1'h0;
		repeat (2) @(posedge sys_clk);
		chk({31'h0, srq_gated}, 32'h0);
		ce <= 1'h0;
		dma_service_request <= 1'h1;
		repeat (2) @(posedge sys_clk);
		chk({31'h0, srq_gated}, 32'h0);
		ce <= 1'h1;
		repeat (2) @(posedge sys_clk);
		chk({31'h0, srq_gated}, 32'h1);
		$display("t_srq done");
	endtask : t_srq

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	// Main sequence.
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'h1;
		t_xfer;
		t_modes;
		t_enum;
		t_loop;
		t_srq;
		print_verdict;
	end

	// Watchdog against a hung handshake.
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		print_verdict;
	end
endmodule : io_interface_diagnose_modes_test

`default_nettype wire
